// ==== rtl/ctrl_chan_pkg.sv ====
// Purpose: Shared constants and types for the control channel config bank
// Assumes: APB, 32-bit data, byte offsets are four times register index
// Notes:   Capability registers at indices 0x1E/0x1F hold frozen values
package ctrl_chan_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register indices as printed; byte address is index times four
  localparam logic [7:0] IDX_CAP_A      = 8'h1E;
  localparam logic [7:0] IDX_CAP_B      = 8'h1F;
  localparam logic [7:0] IDX_BCC_CFG    = 8'h32;
  localparam logic [7:0] IDX_DP_CTL1    = 8'h33;
  localparam logic [7:0] IDX_RSVD_34    = 8'h34;
  localparam logic [7:0] IDX_CAPS_ONE   = 8'h35;
  localparam logic [7:0] IDX_LINK_STAT  = 8'h36;

  localparam logic [7:0] RST_BCC_CFG    = 8'h09;
  localparam logic [7:0] RST_DP_CTL1    = 8'h04;
  localparam logic [7:0] RST_RSVD_34    = 8'h00;
  localparam logic [7:0] RST_CAPS_ONE   = 8'h00;
  localparam logic [7:0] RST_CAP_A      = 8'h00;
  localparam logic [7:0] RST_CAP_B      = 8'h00;

  localparam int unsigned BIT_PASS_ALL   = 7;
  localparam int unsigned BIT_PASS_MATCH = 6;
  localparam int unsigned BIT_ACK_ALL    = 5;
  localparam int unsigned BIT_PARITY_EN  = 3;
  localparam int unsigned BIT_CRC_EN     = 2;
  localparam int unsigned BIT_FREEZE     = 7;
  localparam int unsigned BIT_SELF_TEST  = 5;

  localparam int unsigned CS_BYTES       = 8;

  localparam logic [7:0] CRC_POLY        = 8'h07;
  localparam logic [7:0] CRC_INIT        = 8'hFF;

  typedef struct packed {
    logic       valid;
    logic       self_test;
    logic [7:0] cap_a;
    logic [7:0] cap_b;
  } caps_s;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } byte_s;

endpackage : ctrl_chan_pkg

// ==== rtl/cs_crc_gen.sv ====
// Purpose: Appends CRC byte after eight control sequence bytes
// Assumes: Bytes arrive one per cycle when valid, first byte starts count
// Notes:   CRC byte follows the eighth byte in the next cycle
`timescale 1ns/100ps
`default_nettype none
module cs_crc_gen
(
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 crc_en_i,
  input  wire ctrl_chan_pkg::byte_s in_i,
  output var  ctrl_chan_pkg::byte_s out_o
);

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ ctrl_chan_pkg::CRC_POLY) : (r << 1);
    return r;
  endfunction : crc8

  logic [3:0] cnt_q;
  logic [7:0] crc_q;
  logic       ins_q;
  ctrl_chan_pkg::byte_s out_q;

  wire logic       eighth = in_i.valid &&
                   (cnt_q == 4'(ctrl_chan_pkg::CS_BYTES - 1));
  wire logic [7:0] crc_nx = crc8(crc_q, in_i.data);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= '0;
      crc_q <= ctrl_chan_pkg::CRC_INIT;
      ins_q <= 1'b0;
      out_q <= '0;
    end
    else
    begin
      ins_q <= eighth && crc_en_i;
      if (ins_q)
        out_q <= '{valid: 1'b1, last: 1'b1, data: crc_q};
      else
        out_q <= '{valid: in_i.valid,
                   last: in_i.valid && eighth && !crc_en_i,
                   data: in_i.data};
      if (in_i.valid)
      begin
        cnt_q <= eighth ? '0 : cnt_q + 4'h1;
        crc_q <= eighth ? crc_q : crc_nx;
      end
      if (eighth)
        crc_q <= ctrl_chan_pkg::CRC_INIT;
      if (eighth && crc_en_i)
        crc_q <= crc_nx;
      if (ins_q)
        crc_q <= ctrl_chan_pkg::CRC_INIT;
    end
  end

  assign out_o = out_q;

  property p_crc_after_eighth;
    @(posedge clk_i) disable iff (!arst_n_i)
    (eighth && crc_en_i) |=> ##1 (out_o.valid && out_o.last);
  endproperty
  a_crc_after_eighth: assert property (p_crc_after_eighth)
    else $error("CRC byte not sent after eighth byte");

  property p_no_crc_when_off;
    @(posedge clk_i) disable iff (!arst_n_i)
    (eighth && !crc_en_i) |=> (out_o.last && !ins_q);
  endproperty
  a_no_crc_when_off: assert property (p_no_crc_when_off)
    else $error("CRC inserted while disabled");

  c_crc_sent: cover property (@(posedge clk_i) ins_q);

endmodule : cs_crc_gen
`default_nettype wire

// ==== rtl/i2c_fwd_policy.sv ====
// Purpose: Forward and acknowledge decision for a local I2C transaction
// Assumes: Request pulse with match flag; remote ack result valid in the same cycle as the request
// Notes:   Pure decode, registered one cycle
`timescale 1ns/100ps
`default_nettype none
module i2c_fwd_policy
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic pass_all_i,
  input  wire logic pass_match_i,
  input  wire logic ack_all_i,
  input  wire logic req_i,
  input  wire logic is_write_i,
  input  wire logic match_i,
  input  wire logic fc_lock_i,
  input  wire logic remote_ack_i,
  output var  logic fwd_o,
  output var  logic ack_o
);

  wire logic fwd_d = req_i && (pass_all_i
                     || (pass_match_i && match_i));
  wire logic ack_d = req_i && ((ack_all_i && is_write_i)
                     || (fc_lock_i && remote_ack_i));

  logic fwd_q;
  logic ack_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fwd_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      fwd_q <= fwd_d;
      ack_q <= ack_d;
    end
  end

  assign fwd_o = fwd_q;
  assign ack_o = ack_q;

  property p_pass_all;
    @(posedge clk_i) disable iff (!arst_n_i)
    (req_i && pass_all_i) |=> fwd_o;
  endproperty
  a_pass_all: assert property (p_pass_all)
    else $error("Transaction not forwarded under pass-all");

  property p_match_only;
    @(posedge clk_i) disable iff (!arst_n_i)
    (req_i && !pass_all_i && !(pass_match_i && match_i)) |=> !fwd_o;
  endproperty
  a_match_only: assert property (p_match_only)
    else $error("Forwarded without decode match");

  property p_ack_all;
    @(posedge clk_i) disable iff (!arst_n_i)
    (req_i && is_write_i && ack_all_i && !fc_lock_i) |=> ack_o;
  endproperty
  a_ack_all: assert property (p_ack_all)
    else $error("Write not acknowledged under ack-all");

  c_fwd_match: cover property (@(posedge clk_i)
    req_i && pass_match_i && match_i && !pass_all_i);

endmodule : i2c_fwd_policy
`default_nettype wire

// ==== rtl/control_channel_config.sv ====
// Purpose: APB register bank for control channel and forward datapath
// Assumes: Single clock; link-side inputs already synchronous
// Notes:   Zero wait states; unmapped addresses read zero with pslverr
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Pass-all bit forwards every I2C transaction
// - Match bit forwards only decoded transactions
// - Ack-all bit acknowledges every I2C write
// - Parity checked on back channel when enabled
// - CRC enable appends CRC to sequence
// - CRC covers eight bytes, sent ninth
// - Two-bit field selects zero/one/two/four GPIOs
// - Freeze bit stops capability auto-load
// - Frozen capabilities come from 0x1E/0x1F
// - Self-test bit shows partner self-test request
// - Auto-fill on link detect, freeze keeps write
module control_channel_config
(
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic                 i2c_req_i,
  input  wire logic                 i2c_write_i,
  input  wire logic                 i2c_match_i,
  input  wire logic                 fc_lock_i,
  input  wire logic                 remote_ack_i,
  output var  logic                 i2c_fwd_o,
  output var  logic                 i2c_ack_o,
  input  wire logic                 bc_valid_i,
  input  wire logic [8:0]           bc_data_i,
  output var  logic                 bc_parity_err_o,
  input  wire ctrl_chan_pkg::caps_s link_caps_i,
  output var  ctrl_chan_pkg::caps_s caps_o,
  input  wire ctrl_chan_pkg::byte_s cs_i,
  output var  ctrl_chan_pkg::byte_s cs_o,
  input  wire logic [3:0]           gpio_i,
  output var  logic [3:0]           fwd_gpio_o
);

  logic [7:0] bcc_q;
  logic [7:0] dp_q;
  logic [7:0] rsvd_q;
  logic [7:0] caps1_q;
  logic [7:0] cap_a_q;
  logic [7:0] cap_b_q;
  logic       link_seen_q;
  logic       perr_q;
  logic [3:0] gpio_q;
  logic [31:0] rdata_q;
  logic        err_q;

  // Address decode; low two bits must be zero for a word access
  wire logic [7:0] idx     = paddr[9:2];
  wire logic       aligned = (paddr[1:0] == 2'b00) &&
                             (paddr[31:10] == '0);
  wire logic       setup   = psel && !penable;
  wire logic       wr_acc  = psel && penable && pwrite && pstrb[0];
  wire logic       sel_bcc   = aligned && idx == ctrl_chan_pkg::IDX_BCC_CFG;
  wire logic       sel_dp    = aligned && idx == ctrl_chan_pkg::IDX_DP_CTL1;
  wire logic       sel_rsvd  = aligned && idx == ctrl_chan_pkg::IDX_RSVD_34;
  wire logic       sel_caps1 = aligned &&
                               idx == ctrl_chan_pkg::IDX_CAPS_ONE;
  wire logic       sel_capa  = aligned && idx == ctrl_chan_pkg::IDX_CAP_A;
  wire logic       sel_capb  = aligned && idx == ctrl_chan_pkg::IDX_CAP_B;
  wire logic       sel_stat  = aligned &&
                               idx == ctrl_chan_pkg::IDX_LINK_STAT;
  wire logic       mapped    = sel_bcc | sel_dp | sel_rsvd | sel_caps1 |
                               sel_capa | sel_capb | sel_stat;

  wire logic frozen    = caps1_q[ctrl_chan_pkg::BIT_FREEZE];
  wire logic auto_load = link_caps_i.valid && !frozen;
  wire logic sw_caps1  = wr_acc && sel_caps1;

  // Software write wins over an auto-load in the same cycle whatever freeze
  // value is written; the link self-test value of that cycle is then dropped
  wire logic [7:0] caps1_d =
    sw_caps1  ? pwdata[7:0] :
    auto_load ? {caps1_q[7:6], link_caps_i.self_test,
                 caps1_q[4:0]} :
    caps1_q;

  wire logic [7:0] rd_mux =
    sel_bcc   ? bcc_q   :
    sel_dp    ? dp_q    :
    sel_rsvd  ? rsvd_q  :
    sel_caps1 ? caps1_q :
    sel_capa  ? cap_a_q :
    sel_capb  ? cap_b_q :
    sel_stat  ? {6'h00, perr_q, link_seen_q} : 8'h00;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bcc_q   <= ctrl_chan_pkg::RST_BCC_CFG;
      dp_q    <= ctrl_chan_pkg::RST_DP_CTL1;
      rsvd_q  <= ctrl_chan_pkg::RST_RSVD_34;
      caps1_q <= ctrl_chan_pkg::RST_CAPS_ONE;
      cap_a_q <= ctrl_chan_pkg::RST_CAP_A;
      cap_b_q <= ctrl_chan_pkg::RST_CAP_B;
    end
    else
    begin
      if (wr_acc && sel_bcc)
        bcc_q <= pwdata[7:0];
      if (wr_acc && sel_dp)
        dp_q <= pwdata[7:0];
      if (wr_acc && sel_rsvd)
        rsvd_q <= pwdata[7:0];
      caps1_q <= caps1_d;
      if (wr_acc && sel_capa)
        cap_a_q <= pwdata[7:0];
      else if (auto_load)
        cap_a_q <= link_caps_i.cap_a;
      if (wr_acc && sel_capb)
        cap_b_q <= pwdata[7:0];
      else if (auto_load)
        cap_b_q <= link_caps_i.cap_b;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      err_q   <= !mapped;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

  // Back-channel parity: bit 8 is even parity over the byte
  wire logic par_bad = bc_valid_i && (^bc_data_i) &&
                       bcc_q[ctrl_chan_pkg::BIT_PARITY_EN];

  // Forward GPIO count decode
  function automatic logic [3:0] gpio_mask(input logic [1:0] sel);
    case (sel)
      2'b00:   return 4'h0;
      2'b01:   return 4'h1;
      2'b10:   return 4'h3;
      2'b11:   return 4'hF;
      default: return 4'h0;
    endcase
  endfunction : gpio_mask

  wire logic [3:0] gpio_en = gpio_mask(dp_q[1:0]);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      link_seen_q <= 1'b0;
      perr_q      <= 1'b0;
      gpio_q      <= '0;
    end
    else
    begin
      if (link_caps_i.valid)
        link_seen_q <= 1'b1;
      perr_q <= par_bad;
      gpio_q <= gpio_i & gpio_en;
    end
  end

  assign bc_parity_err_o = perr_q;
  assign fwd_gpio_o      = gpio_q;
  assign caps_o = '{valid:     link_seen_q,
                    self_test: caps1_q[ctrl_chan_pkg::BIT_SELF_TEST],
                    cap_a:     cap_a_q,
                    cap_b:     cap_b_q};

  i2c_fwd_policy u_policy
  (
    .clk_i        (clk_i),
    .arst_n_i     (arst_n_i),
    .pass_all_i   (bcc_q[ctrl_chan_pkg::BIT_PASS_ALL]),
    .pass_match_i (bcc_q[ctrl_chan_pkg::BIT_PASS_MATCH]),
    .ack_all_i    (bcc_q[ctrl_chan_pkg::BIT_ACK_ALL]),
    .req_i        (i2c_req_i),
    .is_write_i   (i2c_write_i),
    .match_i      (i2c_match_i),
    .fc_lock_i    (fc_lock_i),
    .remote_ack_i (remote_ack_i),
    .fwd_o        (i2c_fwd_o),
    .ack_o        (i2c_ack_o)
  );

  cs_crc_gen u_crc
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .crc_en_i (dp_q[ctrl_chan_pkg::BIT_CRC_EN]),
    .in_i     (cs_i),
    .out_o    (cs_o)
  );

  property p_parity_flag;
    @(posedge clk_i) disable iff (!arst_n_i)
    (bc_valid_i && (^bc_data_i) && bcc_q[ctrl_chan_pkg::BIT_PARITY_EN])
      |=> bc_parity_err_o;
  endproperty
  a_parity_flag: assert property (p_parity_flag)
    else $error("Parity error not flagged");

  property p_parity_off;
    @(posedge clk_i) disable iff (!arst_n_i)
    !bcc_q[ctrl_chan_pkg::BIT_PARITY_EN] |=> !bc_parity_err_o;
  endproperty
  a_parity_off: assert property (p_parity_off)
    else $error("Parity flagged while checker off");

  property p_gpio_count;
    @(posedge clk_i) disable iff (!arst_n_i)
    (dp_q[1:0] == 2'b01) |=> (fwd_gpio_o[3:1] == 3'h0);
  endproperty
  a_gpio_count: assert property (p_gpio_count)
    else $error("Extra GPIO forwarded");

  property p_freeze_holds;
    @(posedge clk_i) disable iff (!arst_n_i)
    (frozen && !(wr_acc && (sel_capa || sel_caps1))) |=>
      (cap_a_q == $past(cap_a_q) && caps_o.self_test ==
       $past(caps1_q[ctrl_chan_pkg::BIT_SELF_TEST]));
  endproperty
  a_freeze_holds: assert property (p_freeze_holds)
    else $error("Capabilities changed while frozen");

  property p_frozen_value;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_acc && sel_capb) |=> (caps_o.cap_b == $past(pwdata[7:0]));
  endproperty
  a_frozen_value: assert property (p_frozen_value)
    else $error("Written capability not used");

  property p_auto_fill;
    @(posedge clk_i) disable iff (!arst_n_i)
    (auto_load && !sw_caps1) |=> (caps_o.self_test == $past(
      link_caps_i.self_test));
  endproperty
  a_auto_fill: assert property (p_auto_fill)
    else $error("Self-test bit not auto-filled");

  property p_readback;
    @(posedge clk_i) disable iff (!arst_n_i)
    (setup && !pwrite && sel_bcc)
      |=> (prdata[7:0] == $past(bcc_q));
  endproperty
  a_readback: assert property (p_readback)
    else $error("Read-back mismatch");

  c_freeze_write: cover property (@(posedge clk_i) sw_caps1 &&
    pwdata[ctrl_chan_pkg::BIT_FREEZE]);
  c_unmapped: cover property (@(posedge clk_i) pslverr);
  c_auto_load: cover property (@(posedge clk_i) auto_load);

endmodule : control_channel_config
`default_nettype wire

// ==== sim/remote_link_model.sv ====
// Purpose: Far-end deserializer stand-in for the control channel bank
// Assumes: Back-channel traffic arrives already synchronous to clk_i
// Notes:   Released back-channel lines toggle so stale data cannot pass
`timescale 1ns/100ps
`default_nettype none
module remote_link_model
(
  input  wire logic                 clk_i,
  input  wire ctrl_chan_pkg::byte_s cs_i,
  output var  logic                 bc_valid_o,
  output var  logic [8:0]           bc_data_o,
  output var  ctrl_chan_pkg::caps_s link_caps_o
);
  logic [8:0] rx_q [$];

  initial
  begin
    bc_valid_o = 1'b0;
    bc_data_o = 9'h000;
    link_caps_o = '0;
  end

  // Receiver keeps every byte with its end marker for a CRC check
  always @(posedge clk_i)
    if (cs_i.valid === 1'b1)
      rx_q.push_back({cs_i.last, cs_i.data});

  task automatic send_bc(input logic [7:0] d, input logic bad);
    @(posedge clk_i);
    bc_valid_o <= 1'b1;
    bc_data_o <= {(^d) ^ bad, d};
    @(posedge clk_i);
    bc_valid_o <= 1'b0;
    bc_data_o <= ~bc_data_o;
  endtask : send_bc

  // Capability report once the back channel is up
  task automatic send_caps(input logic st, input logic [7:0] a, b);
    @(posedge clk_i);
    link_caps_o <= {1'b1, st, a, b};
    @(posedge clk_i);
    link_caps_o <= {1'b0, ~st, ~a, ~b};
  endtask : send_caps
endmodule : remote_link_model
`default_nettype wire

// ==== sim/control_channel_config_bench.sv ====
// Purpose: Self-checking bench for the control channel config bank
// Assumes: Zero-wait APB slave, one-cycle registered side outputs
// Notes:   Expected values come from integer models in this file
`timescale 1ns/100ps
`default_nettype none
module control_channel_config_bench;
  logic                 clk_i, arst_n_i, psel, penable, pwrite;
  logic                 pready, pslverr, err;
  logic [31:0]          paddr, pwdata, prdata, seed_q, rd, v;
  logic [3:0]           pstrb, gpio_i, fwd_gpio_o;
  logic                 i2c_req_i, i2c_write_i, i2c_match_i;
  logic                 fc_lock_i, remote_ack_i, i2c_fwd_o, i2c_ack_o;
  logic                 bc_valid_i, bc_parity_err_o;
  logic [8:0]           bc_data_i;
  logic [7:0]           crc;
  logic [7:0]           b [8];
  ctrl_chan_pkg::caps_s link_caps_i, caps_o;
  ctrl_chan_pkg::byte_s cs_i, cs_o;
  int                   errors, samples_checked, m;
  int                   exp_reg [int];

  control_channel_config dut (.clk_i, .arst_n_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .i2c_req_i,
    .i2c_write_i, .i2c_match_i, .fc_lock_i, .remote_ack_i, .i2c_fwd_o,
    .i2c_ack_o, .bc_valid_i, .bc_data_i, .bc_parity_err_o, .link_caps_i,
    .caps_o, .cs_i, .cs_o, .gpio_i, .fwd_gpio_o);

  remote_link_model remote (.clk_i, .cs_i(cs_o), .bc_valid_o(bc_valid_i),
    .bc_data_o(bc_data_i), .link_caps_o(link_caps_i));

  function automatic logic [31:0] rnd();
    seed_q = {seed_q[30:0], seed_q[31] ^ seed_q[21] ^ seed_q[1] ^ seed_q[0]};
    return seed_q;
  endfunction : rnd

  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    c = c ^ d;
    for (int i = 0; i < 8; i++)
      c = c[7] ? {c[6:0], 1'b0} ^ ctrl_chan_pkg::CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction : crc8

  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      check(0, 1, "apb timeout");
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    exp_reg[idx] = int'(d[7:0]);
  endtask : wr_reg

  task automatic rd_chk(input int idx);
    apb(1'b0, 8'(idx), 32'h0);
    check(rd, exp_reg[idx], "register read");
    check(err, 0, "pslverr on mapped");
  endtask : rd_chk

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (100000) @(posedge clk_i);
    check(0, 1, "run timeout");
    report_and_stop();
  end

  initial
  begin
    {arst_n_i, psel, penable, pwrite, paddr, pwdata, i2c_req_i} = '0;
    {i2c_write_i, i2c_match_i, fc_lock_i, remote_ack_i, gpio_i} = '0;
    pstrb = 4'hF;
    cs_i = '0;
    seed_q = 32'h08C3;
    errors = 0;
    samples_checked = 0;
    exp_reg = '{8'h32: 8'h09, 8'h33: 8'h04, 8'h34: 0, 8'h35: 0,
                8'h1E: 0, 8'h1F: 0, 8'h36: 0};
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    foreach (exp_reg[i]) rd_chk(i);
    // Reserved fields always rewritten with their reset values
    repeat (3)
    begin
      wr_reg(8'h32, (rnd() & 32'hE8) | 32'h01);
      wr_reg(8'h33, rnd() & 32'h07);
      wr_reg(8'h35, rnd() & 32'hA0);
      wr_reg(8'h1E, rnd() & 32'hFF);
      wr_reg(8'h1F, rnd() & 32'hFF);
      foreach (exp_reg[i]) rd_chk(i);
    end
    apb(1'b1, 8'h40, 32'hFF);
    check(err, 1, "unmapped write error");
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1, "unmapped read error");
    check(rd, 32'h0000_0000, "unmapped read data");
    @(posedge clk_i);
    pstrb <= 4'h0;
    apb(1'b1, 8'h1E, 32'h77);
    pstrb <= 4'hF;
    foreach (exp_reg[i]) rd_chk(i);
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(8'h32, {24'h0, c[2:0], 5'h09});
      repeat (8)
      begin
        v = rnd();
        @(posedge clk_i);
        i2c_req_i <= 1'b1;
        {remote_ack_i, fc_lock_i, i2c_match_i, i2c_write_i} <= v[3:0];
        @(posedge clk_i);
        i2c_req_i <= 1'b0;
        #1;
        check(i2c_fwd_o, c[2] | (c[1] & v[1]), "forward");
        check(i2c_ack_o, (c[0] & v[0]) | (v[2] & v[3]), "ack");
      end
    end
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h32, c[1] ? 32'h09 : 32'h01);
      v = rnd();
      remote.send_bc(v[7:0], c[0]);
      #1;
      check(bc_parity_err_o, c[1] & c[0], "parity");
    end
    for (int c = 0; c < 2; c++)
    begin
      wr_reg(8'h33, {29'h0, c[0], 2'b00});
      remote.rx_q.delete();
      crc = ctrl_chan_pkg::CRC_INIT;
      for (int k = 0; k < 8; k++)
      begin
        v = rnd();
        b[k] = v[7:0];
        crc = crc8(crc, v[7:0]);
        @(posedge clk_i);
        cs_i <= {1'b1, k == 7, v[7:0]};
      end
      @(posedge clk_i);
      cs_i <= '0;
      repeat (4) @(posedge clk_i);
      check(remote.rx_q.size(), 8 + c, "sequence length");
      for (int k = 0; k < 8; k++)
        check(remote.rx_q[k], {k == 7 && c == 0, b[k]}, "byte");
      if (c == 1)
        check(remote.rx_q[8], {1'b1, crc}, "crc byte");
    end
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h33, 32'h04 | c);
      m = (1 << (c == 3 ? 4 : c)) - 1;
      v = rnd();
      @(posedge clk_i);
      gpio_i <= v[3:0];
      @(posedge clk_i);
      #1;
      check(fwd_gpio_o, v[3:0] & m[3:0], "gpio count");
    end
    wr_reg(8'h35, 32'h0);
    v = rnd();
    remote.send_caps(1'b1, v[7:0], v[15:8]);
    repeat (2) @(posedge clk_i);
    exp_reg[8'h1E] = int'(v[7:0]);
    exp_reg[8'h1F] = int'(v[15:8]);
    exp_reg[8'h35] = 8'h20;
    exp_reg[8'h36] = 1;
    foreach (exp_reg[i]) rd_chk(i);
    // Software copy wins only while frozen
    wr_reg(8'h35, 32'hA0);
    wr_reg(8'h1E, {24'h0, v[15:8]});
    wr_reg(8'h1F, {24'h0, v[7:0]});
    remote.send_caps(1'b0, ~v[7:0], ~v[23:16]);
    repeat (3) @(posedge clk_i);
    #1;
    check({caps_o.valid, caps_o.self_test, caps_o.cap_a, caps_o.cap_b},
          {2'b11, v[15:8], v[7:0]}, "frozen caps");
    foreach (exp_reg[i]) rd_chk(i);
    // Mid-run reset must bring every register back to its reset value
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    exp_reg = '{8'h32: 8'h09, 8'h33: 8'h04, 8'h34: 0, 8'h35: 0,
                8'h1E: 0, 8'h1F: 0, 8'h36: 0};
    check(caps_o.valid, 1'b0, "link seen after reset");
    foreach (exp_reg[i]) rd_chk(i);
    report_and_stop();
  end
endmodule : control_channel_config_bench
`default_nettype wire
